// ==== rtl/pgm_pkg.sv ====
package pgm_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] PGM_P5_DIR_ADDR   = 16'hFFB8;
  localparam logic [15:0] PGM_P6_DIR_ADDR   = 16'hFFB9;
  localparam logic [15:0] PGM_P5_LATCH_ADDR = 16'hFFBA;
  localparam logic [15:0] PGM_P6_LATCH_ADDR = 16'hFFBB;
  localparam logic [15:0] PGM_P6_PULL_ADDR  = 16'hFFF2;

  // ------------------------------------------------------------
  // reset values and read constants
  // ------------------------------------------------------------
  localparam logic [7:0] PGM_P6_RST      = 8'h00;
  localparam logic [2:0] PGM_P5_RST      = 3'h0;
  localparam logic [4:0] PGM_P5_RSVD     = 5'h1F;
  localparam logic [7:0] PGM_WO_READ     = 8'hFF;
  localparam logic [7:0] PGM_UNMAPPED    = 8'hFF;

  // ------------------------------------------------------------
  // port 5 bit positions
  // ------------------------------------------------------------
  localparam int PGM_P5_TX_BIT  = 0;
  localparam int PGM_P5_RX_BIT  = 1;
  localparam int PGM_P5_CLK_BIT = 2;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic clk_mode_sync;
    logic clock_output_enable;
    logic external_clock_select;
    logic receiver_on;
    logic transmitter_on;
  } pgm_serial_ctl_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pgm_drive8_s;

  typedef enum logic [2:0] {
    PGM_RUN    = 3'b001,
    PGM_SWSTBY = 3'b010,
    PGM_HWSTBY = 3'b100
  } pgm_power_e;

endpackage

// ==== rtl/pgm_sync.sv ====
`timescale 1ns/1ps
module pgm_sync
  import pgm_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  // ------------------------------------------------------------
  // three stages, change taken when stages two and three agree
  // ------------------------------------------------------------
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] o_d;
  assign o_d = (s2_q & s3_q) | (o_sync & (s2_q ^ s3_q));
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      o_sync <= '0;
    end else begin
      s1_q   <= i_async;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      o_sync <= o_d;
    end
  end
endmodule

// ==== rtl/pgm_p5_mux.sv ====
`timescale 1ns/1ps
module pgm_p5_mux
  import pgm_pkg::*;
(
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_n,
  input  wire pgm_serial_ctl_s i_ctl,
  input  wire logic [2:0]      i_dir,
  input  wire logic [2:0]      i_latch,
  input  wire logic            i_ser_clk_out,
  input  wire logic            i_ser_tx,
  output logic      [2:0]      o_pin_out,
  output logic      [2:0]      o_pin_oe,
  output logic                 o_clk_is_input,
  output logic                 o_rx_is_serial
);
  // ------------------------------------------------------------
  // pin function selection, control bits only
  // ------------------------------------------------------------
  logic       clk_out_sel;
  logic [2:0] out_d;
  logic [2:0] oe_d;
  assign clk_out_sel = !i_ctl.external_clock_select &&
                       (i_ctl.clk_mode_sync || i_ctl.clock_output_enable);
  assign oe_d[PGM_P5_CLK_BIT] = i_ctl.external_clock_select ? 1'b0 :
                                clk_out_sel ? 1'b1 : i_dir[PGM_P5_CLK_BIT];
  assign out_d[PGM_P5_CLK_BIT] = clk_out_sel ? i_ser_clk_out : i_latch[PGM_P5_CLK_BIT];
  assign oe_d[PGM_P5_RX_BIT]  = i_ctl.receiver_on ? 1'b0 : i_dir[PGM_P5_RX_BIT];
  assign out_d[PGM_P5_RX_BIT] = i_latch[PGM_P5_RX_BIT];
  assign oe_d[PGM_P5_TX_BIT]  = i_ctl.transmitter_on | i_dir[PGM_P5_TX_BIT];
  assign out_d[PGM_P5_TX_BIT] = i_ctl.transmitter_on ? i_ser_tx : i_latch[PGM_P5_TX_BIT];

  assign o_clk_is_input = i_ctl.external_clock_select;
  assign o_rx_is_serial = i_ctl.receiver_on;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin_out <= '0;
      o_pin_oe  <= '0;
    end else begin
      o_pin_out <= out_d;
      o_pin_oe  <= oe_d;
    end
  end
endmodule

// ==== rtl/pgm_gpio_top.sv ====
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module pgm_gpio_top
  import pgm_pkg::*;
(
  input  wire logic            i_clk_sys,
  input  wire logic            i_rst_n,
  input  wire logic            i_hw_standby,
  input  wire logic            i_sw_standby,
  input  wire logic [15:0]     i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [7:0]      o_rdata,
  input  wire pgm_serial_ctl_s i_ser_ctl,
  input  wire logic            i_ser_clk_out,
  input  wire logic            i_ser_tx,
  output logic                 o_ser_clk_in,
  output logic                 o_ser_rx,
  input  wire logic [2:0]      i_p5_pin,
  output logic      [2:0]      o_p5_out,
  output logic      [2:0]      o_p5_oe,
  input  wire logic [7:0]      i_p6_pin,
  output logic      [7:0]      o_p6_out,
  output logic      [7:0]      o_p6_oe,
  output logic      [7:0]      o_p6_pullup,
  input  wire logic [7:0]      i_tmr_out,
  input  wire logic [7:0]      i_tmr_oe,
  output logic      [7:0]      o_tmr_in,
  output logic                 o_tmr_init,
  output logic      [2:0]      o_power_state
);
  // ------------------------------------------------------------
  // power state
  // ------------------------------------------------------------
  pgm_power_e pwr_q;
  pgm_power_e pwr_d;
  assign pwr_d = i_hw_standby ? PGM_HWSTBY : (i_sw_standby ? PGM_SWSTBY : PGM_RUN);
  assign o_power_state = pwr_q;
  wire hw_clr = i_hw_standby;
  wire stby_any = (pwr_q != PGM_RUN);

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------
  wire wr_p5_dir   = i_wr && (i_addr == PGM_P5_DIR_ADDR);
  wire wr_p6_dir   = i_wr && (i_addr == PGM_P6_DIR_ADDR);
  wire wr_p5_latch = i_wr && (i_addr == PGM_P5_LATCH_ADDR);
  wire wr_p6_latch = i_wr && (i_addr == PGM_P6_LATCH_ADDR);
  wire wr_p6_pull  = i_wr && (i_addr == PGM_P6_PULL_ADDR);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] p6_dir_q;
  logic [7:0] p6_latch_q;
  logic [7:0] p6_pull_q;
  logic [2:0] p5_dir_q;
  logic [2:0] p5_latch_q;
  logic [7:0] p6_dir_d;
  logic [7:0] p6_latch_d;
  logic [7:0] p6_pull_d;
  logic [2:0] p5_dir_d;
  logic [2:0] p5_latch_d;

  assign p6_dir_d   = hw_clr ? PGM_P6_RST : (wr_p6_dir ? i_wdata : p6_dir_q);
  assign p6_latch_d = hw_clr ? PGM_P6_RST : (wr_p6_latch ? i_wdata : p6_latch_q);
  assign p6_pull_d  = hw_clr ? PGM_P6_RST : (wr_p6_pull ? i_wdata : p6_pull_q);
  assign p5_dir_d   = hw_clr ? PGM_P5_RST : (wr_p5_dir ? i_wdata[2:0] : p5_dir_q);
  assign p5_latch_d = hw_clr ? PGM_P5_RST : (wr_p5_latch ? i_wdata[2:0] : p5_latch_q);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_q      <= PGM_RUN;
      p6_dir_q   <= PGM_P6_RST;
      p6_latch_q <= PGM_P6_RST;
      p6_pull_q  <= PGM_P6_RST;
      p5_dir_q   <= PGM_P5_RST;
      p5_latch_q <= PGM_P5_RST;
    end else begin
      pwr_q      <= pwr_d;
      p6_dir_q   <= p6_dir_d;
      p6_latch_q <= p6_latch_d;
      p6_pull_q  <= p6_pull_d;
      p5_dir_q   <= p5_dir_d;
      p5_latch_q <= p5_latch_d;
    end
  end

  // ------------------------------------------------------------
  // pin input synchronisers
  // ------------------------------------------------------------
  logic [7:0] p6_pin_s;
  logic [2:0] p5_pin_s;
  pgm_sync #(.W(8)) u_sync6 (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_p6_pin),
    .o_sync    (p6_pin_s)
  );
  pgm_sync #(.W(3)) u_sync5 (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_p5_pin),
    .o_sync    (p5_pin_s)
  );

  // ------------------------------------------------------------
  // port 5 pin functions
  // ------------------------------------------------------------
  pgm_serial_ctl_s ser_ctl_eff;
  assign ser_ctl_eff = stby_any ? '0 : i_ser_ctl;
  pgm_p5_mux u_p5 (
    .i_clk_sys      (i_clk_sys),
    .i_rst_n        (i_rst_n),
    .i_ctl          (ser_ctl_eff),
    .i_dir          (p5_dir_q),
    .i_latch        (p5_latch_q),
    .i_ser_clk_out  (i_ser_clk_out),
    .i_ser_tx       (i_ser_tx),
    .o_pin_out      (o_p5_out),
    .o_pin_oe       (o_p5_oe),
    .o_clk_is_input (),
    .o_rx_is_serial ()
  );
  assign o_ser_clk_in = p5_pin_s[PGM_P5_CLK_BIT];
  assign o_ser_rx     = p5_pin_s[PGM_P5_RX_BIT];

  // ------------------------------------------------------------
  // port 6 pin drive
  // ------------------------------------------------------------
  logic [7:0] tmr_oe_eff;
  pgm_drive8_s p6_drv_d;
  pgm_drive8_s p6_drv_q;
  logic [7:0] pull_d;
  logic [7:0] pull_q;
  logic       tmr_init_q;
  assign tmr_oe_eff   = stby_any ? 8'h00 : i_tmr_oe;
  assign p6_drv_d.oe  = p6_dir_q | tmr_oe_eff;
  assign p6_drv_d.out = (tmr_oe_eff & i_tmr_out) | (~tmr_oe_eff & p6_latch_q);
  assign pull_d       = ~p6_dir_q & p6_pull_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p6_drv_q   <= '0;
      pull_q     <= '0;
      tmr_init_q <= 1'b0;
    end else begin
      p6_drv_q   <= p6_drv_d;
      pull_q     <= pull_d;
      tmr_init_q <= (pwr_d == PGM_SWSTBY);
    end
  end
  assign o_p6_out    = p6_drv_q.out;
  assign o_p6_oe     = p6_drv_q.oe;
  assign o_p6_pullup = pull_q;
  assign o_tmr_in    = p6_pin_s;
  assign o_tmr_init  = tmr_init_q;

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  logic [7:0] rd_d;
  logic [7:0] rdata_q;
  wire  [7:0] p6_view = (p6_dir_q & p6_latch_q) | (~p6_dir_q & p6_pin_s);
  wire  [2:0] p5_view = (p5_dir_q & p5_latch_q) | (~p5_dir_q & p5_pin_s);
  always_comb begin
    unique case (i_addr)
      PGM_P6_DIR_ADDR:   rd_d = PGM_WO_READ;
      PGM_P5_DIR_ADDR:   rd_d = PGM_WO_READ;
      PGM_P6_LATCH_ADDR: rd_d = p6_view;
      PGM_P5_LATCH_ADDR: rd_d = {PGM_P5_RSVD, p5_view};
      PGM_P6_PULL_ADDR:  rd_d = p6_pull_q;
      default:           rd_d = PGM_UNMAPPED;
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (i_rd) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= '0;
    end
  end
  assign o_rdata = rdata_q;
endmodule

// ==== test/pgm_pin_model.sv ====
`timescale 1ns/1ps
module pgm_pin_model #(
  parameter int W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_pull,
  input  wire logic [W-1:0] i_ext_val,
  input  wire logic [W-1:0] i_ext_drv,
  output logic      [W-1:0] o_pin
);
  // ----------------------------------------
  // board pins: device, board driver, pull-up, else wander
  // ----------------------------------------
  logic [W-1:0] float_q = '0;
  always @(posedge i_clk_sys) begin
    float_q <= ~float_q;
  end
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_drv & i_ext_val) | (~i_oe & ~i_ext_drv & (i_pull | float_q));
endmodule

// ==== test/pgm_gpio_top_chk.sv ====
`timescale 1ns/1ps
module pgm_gpio_chk
  import pgm_pkg::*;
(
  input wire logic            i_clk_sys,
  input wire logic            i_rst_n,
  input wire logic            i_hw_standby,
  input wire logic            i_sw_standby,
  input wire logic [15:0]     i_addr,
  input wire logic            i_rd,
  input wire logic [7:0]      o_rdata,
  input wire pgm_serial_ctl_s i_ser_ctl,
  input wire logic            i_ser_clk_out,
  input wire logic            i_ser_tx,
  input wire logic [2:0]      o_p5_out,
  input wire logic [2:0]      o_p5_oe,
  input wire logic [7:0]      o_p6_out,
  input wire logic [7:0]      o_p6_oe,
  input wire logic [7:0]      o_p6_pullup,
  input wire logic            o_tmr_init,
  input wire logic [2:0]      o_power_state
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  wire run = !i_sw_standby && !i_hw_standby;
  wire cko = i_ser_ctl.clk_mode_sync || i_ser_ctl.clock_output_enable;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_ext; (run && i_ser_ctl.external_clock_select)[*3]; endsequence
  sequence s_cko; (run && !i_ser_ctl.external_clock_select && cko)[*3]; endsequence
  sequence s_tx; (run && i_ser_ctl.transmitter_on)[*3]; endsequence
  sequence s_rx; (run && i_ser_ctl.receiver_on)[*3]; endsequence
  sequence s_hw; i_hw_standby[*3]; endsequence
  sequence s_sw; (i_sw_standby && !i_hw_standby)[*3]; endsequence
  a_dir_reads_ones: assert property (i_rd && i_addr == PGM_P6_DIR_ADDR |=> o_rdata == PGM_WO_READ)
    else $error("direction read not all ones");
  a_ext_clk_in: assert property (s_ext |-> !o_p5_oe[PGM_P5_CLK_BIT])
    else $error("clock pin driven while external");
  a_clk_out_drive: assert property (s_cko |-> o_p5_oe[2] && o_p5_out[2] == $past(i_ser_clk_out))
    else $error("clock pin not driving serial clock");
  a_tx_pin_drive: assert property (s_tx |-> o_p5_oe[0] && o_p5_out[0] == $past(i_ser_tx))
    else $error("transmit pin not driving serial data");
  a_rx_pin_input: assert property (s_rx |-> !o_p5_oe[1])
    else $error("receive pin driven");
  a_hw_clears_all: assert property (s_hw |-> o_p6_oe == PGM_P6_RST && o_p6_out == PGM_P6_RST && o_p6_pullup == PGM_P6_RST)
    else $error("hardware standby left port 6 active");
  a_sw_timer_init: assert property (s_sw |-> o_tmr_init && o_power_state == PGM_SWSTBY)
    else $error("timer not initialised in software standby");
  a_pull_in_only: assert property (s_sw |-> (o_p6_pullup & o_p6_oe) == 8'h00)
    else $error("pull-up on a driven pin");
endmodule

bind pgm_gpio_top pgm_gpio_chk u_chk (.i_clk_sys, .i_rst_n, .i_hw_standby, .i_sw_standby, .i_addr, .i_rd, .o_rdata,
  .i_ser_ctl, .i_ser_clk_out, .i_ser_tx, .o_p5_out, .o_p5_oe, .o_p6_out, .o_p6_oe, .o_p6_pullup, .o_tmr_init,
  .o_power_state);

// ==== test/test_port5_port6_gpio_mux.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_port5_port6_gpio_mux
  import pgm_pkg::*;
;
  logic            i_clk_sys = 1'b0;
  logic            i_rst_n, i_hw_standby, i_sw_standby, i_wr, i_rd, i_ser_clk_out, i_ser_tx;
  logic            o_ser_clk_in, o_ser_rx, o_tmr_init;
  logic [15:0]     i_addr;
  logic [7:0]      i_wdata, o_rdata, i_p6_pin, o_p6_out, o_p6_oe, o_p6_pullup, i_tmr_out, i_tmr_oe, o_tmr_in;
  logic [7:0]      ext6_val, ext6_drv;
  logic [2:0]      i_p5_pin, o_p5_out, o_p5_oe, o_power_state, ext5_val, ext5_drv, eo;
  pgm_serial_ctl_s i_ser_ctl;
  int              err_total, checks_done;
  // ----------------------------------------
  // design, pins and bus tasks
  // ----------------------------------------
  always #50 i_clk_sys = ~i_clk_sys;
  pgm_gpio_top DUT (.i_clk_sys, .i_rst_n, .i_hw_standby, .i_sw_standby, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ser_ctl, .i_ser_clk_out, .i_ser_tx, .o_ser_clk_in, .o_ser_rx, .i_p5_pin, .o_p5_out, .o_p5_oe, .i_p6_pin,
    .o_p6_out, .o_p6_oe, .o_p6_pullup, .i_tmr_out, .i_tmr_oe, .o_tmr_in, .o_tmr_init, .o_power_state);
  pgm_pin_model #(.W(8)) u_p6 (.i_clk_sys, .i_out(o_p6_out), .i_oe(o_p6_oe), .i_pull(o_p6_pullup),
    .i_ext_val(ext6_val), .i_ext_drv(ext6_drv), .o_pin(i_p6_pin));
  pgm_pin_model #(.W(3)) u_p5 (.i_clk_sys, .i_out(o_p5_out), .i_oe(o_p5_oe), .i_pull(3'h0),
    .i_ext_val(ext5_val), .i_ext_drv(ext5_drv), .o_pin(i_p5_pin));
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(o_rdata, e)
  endtask
  task automatic settle();
    repeat (5) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {i_rst_n, i_hw_standby, i_sw_standby, i_wr, i_rd, i_ser_clk_out, i_ser_tx, i_addr, i_wdata} = '0;
    {i_tmr_out, i_tmr_oe, ext5_val, ext5_drv, i_ser_ctl} = '0;
    ext6_val = 8'hA5;
    ext6_drv = 8'hFF;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd_chk(PGM_P6_DIR_ADDR, PGM_WO_READ);
    rd_chk(PGM_P6_PULL_ADDR, PGM_P6_RST);
    rd_chk(PGM_P6_LATCH_ADDR, 8'hA5);
    `CHK(o_p6_oe, PGM_P6_RST)
    $display("test reset done");
    ext6_drv <= 8'h0F;
    wr(PGM_P6_DIR_ADDR, 8'hF0);
    wr(PGM_P6_LATCH_ADDR, 8'h3C);
    settle();
    `CHK(o_p6_oe, 8'hF0)
    `CHK(o_p6_out & 8'hF0, 8'h30)
    rd_chk(PGM_P6_LATCH_ADDR, 8'h35);
    rd_chk(PGM_P6_DIR_ADDR, PGM_WO_READ);
    ext6_drv <= 8'h00;
    wr(PGM_P6_PULL_ADDR, 8'hFF);
    settle();
    rd_chk(PGM_P6_PULL_ADDR, 8'hFF);
    `CHK(o_p6_pullup, 8'h0F)
    rd_chk(PGM_P6_LATCH_ADDR, 8'h3F);
    $display("test direction data pullup done");
    @(posedge i_clk_sys);
    i_tmr_oe <= 8'hFF;
    i_tmr_out <= 8'hAA;
    settle();
    rd_chk(PGM_P6_LATCH_ADDR, 8'h3A);
    `CHK(o_tmr_in, 8'hAA)
    @(posedge i_clk_sys);
    i_sw_standby <= 1'b1;
    settle();
    `CHK(o_tmr_init, 1'b1)
    `CHK(o_p6_oe, 8'hF0)
    `CHK(o_p6_out & 8'hF0, 8'h30)
    @(posedge i_clk_sys);
    i_sw_standby <= 1'b0;
    i_tmr_oe <= 8'h00;
    settle();
    rd_chk(PGM_P6_PULL_ADDR, 8'hFF);
    rd_chk(PGM_P6_LATCH_ADDR, 8'h3F);
    $display("test standby done");
    wr(PGM_P5_LATCH_ADDR, 8'h05);
    for (int d = 0; d < 2; d++) begin
      wr(PGM_P5_DIR_ADDR, d[0] ? 8'h07 : 8'h00);
      for (int c = 0; c < 32; c++) begin
        @(posedge i_clk_sys);
        i_ser_ctl <= pgm_serial_ctl_s'(c[4:0]);
        i_ser_clk_out <= c[1];
        i_ser_tx <= c[2];
        settle();
        eo = {c[2] ? 1'b0 : ((c[4] | c[3]) ? 1'b1 : d[0]), c[1] ? 1'b0 : d[0], c[0] | d[0]};
        `CHK(o_p5_oe, eo)
        `CHK(o_p5_out & eo, {(c[4] | c[3]) ? c[1] : 1'b1, 1'b0, c[0] ? c[2] : 1'b1} & eo)
      end
    end
    @(posedge i_clk_sys);
    i_ser_ctl <= pgm_serial_ctl_s'(5'h06);
    ext5_drv <= 3'h6;
    ext5_val <= 3'h2;
    settle();
    `CHK(o_ser_rx, 1'b1)
    `CHK(o_ser_clk_in, 1'b0)
    $display("test port 5 done");
    @(posedge i_clk_sys);
    i_hw_standby <= 1'b1;
    settle();
    ext6_drv <= 8'hFF;
    ext6_val <= 8'h5A;
    `CHK(o_p6_oe, PGM_P6_RST)
    `CHK(o_p6_pullup, PGM_P6_RST)
    wr(PGM_P6_PULL_ADDR, 8'hFF);
    i_hw_standby <= 1'b0;
    settle();
    rd_chk(PGM_P6_PULL_ADDR, PGM_P6_RST);
    rd_chk(PGM_P6_LATCH_ADDR, 8'h5A);
    wr(PGM_P6_DIR_ADDR, 8'hFF);
    rd_chk(PGM_P6_LATCH_ADDR, PGM_P6_RST);
    rd_chk(16'hFFFF, PGM_UNMAPPED);
    $display("test hardware standby done");
    final_report();
  end
endmodule
